//--- ptc_consts.vh
`ifndef PTC_CONSTS_VH
`define PTC_CONSTS_VH
// Instruction fields
`define PTC_OPC_SYSTEM 7'h73
`define PTC_F3_TRAP_MINOR_OP 3'h0
`define PTC_F12_ENV 12'h000
`define PTC_F12_DBG 12'h001
`define PTC_F12_USER_RETURN 12'h002
`define PTC_F12_SUPERVISOR_RETURN 12'h102
`define PTC_F12_TOP_LEVEL_RETURN 12'h302
`define PTC_F12_IDLE 12'h105
`define PTC_SHORT_DBG 16'h9002
// Privilege levels
`define PTC_LVL_U 2'h0
`define PTC_LVL_S 2'h1
`define PTC_LVL_M 2'h3
// Exception codes
`define PTC_EXC_ILLEGAL 5'h02
`define PTC_EXC_BREAK 5'h03
`define PTC_EXC_ENV_U 5'h08
`define PTC_EXC_ENV_S 5'h09
`define PTC_EXC_ENV_M 5'h0b
`define PTC_RESET_CAUSE 5'h00
`define PTC_NMI_CAUSE 5'h00
// Vectors and reset values
`define PTC_RESET_VEC 32'h0000_0000
`define PTC_NMI_VEC 32'h0000_0004
`define PTC_TRAP_VEC 32'h0000_0100
`define PTC_PC_STEP 32'h0000_0004
// Wishbone register map (byte addresses)
`define PTC_REG_CTRL 4'h0
`define PTC_REG_STATUS 4'h4
`define PTC_REG_EPC 4'h8
`define PTC_REG_CAUSE 4'hc
// Selector code that names no register (holes and unaligned words)
`define PTC_REG_HOLE 4'h1
`endif

//--- ptc_decode.v
`include "ptc_consts.vh"
// Classifies one instruction word of the system opcode family
module ptc_decode (
    input wire [31:0] instr,
    output reg is_env,
    output reg is_dbg,
    output reg is_user_return,
    output reg is_supervisor_return,
    output reg is_top_level_return,
    output reg is_idle,
    output reg idle_bad
);
    wire sys_trap_minor_op;
    wire regs_zero;
    wire short_dbg;
    // Major opcode and minor function match
    assign sys_trap_minor_op = (instr[6:0] == `PTC_OPC_SYSTEM) &&
        (instr[14:12] == `PTC_F3_TRAP_MINOR_OP);
    assign regs_zero = (instr[19:15] == 5'h00) && (instr[11:7] == 5'h00);
    // Compressed form sits in low half with upper half zero
    assign short_dbg = (instr[15:0] == `PTC_SHORT_DBG) &&
        (instr[31:16] == 16'h0000);
    // Function field compare
    always @* begin
        is_env = sys_trap_minor_op && regs_zero && instr[31:20] == `PTC_F12_ENV;
        is_dbg = (sys_trap_minor_op && regs_zero && instr[31:20] == `PTC_F12_DBG)
            || short_dbg;
        is_user_return = sys_trap_minor_op && regs_zero && instr[31:20] == `PTC_F12_USER_RETURN;
        is_supervisor_return = sys_trap_minor_op && regs_zero && instr[31:20] == `PTC_F12_SUPERVISOR_RETURN;
        is_top_level_return = sys_trap_minor_op && regs_zero && instr[31:20] == `PTC_F12_TOP_LEVEL_RETURN;
        is_idle = sys_trap_minor_op && regs_zero && instr[31:20] == `PTC_F12_IDLE;
        idle_bad = sys_trap_minor_op && !regs_zero &&
            instr[31:20] == `PTC_F12_IDLE;
    end
endmodule // ptc_decode

//--- ptc_wake.v
// Wakeup detect: individually enabled pending, globals ignored
module ptc_wake #(
    parameter NIRQ = 12
) (
    input wire [NIRQ-1:0] pend,
    input wire [NIRQ-1:0] ena,
    output wire wake
);
    // Any pending interrupt whose own enable is set
    assign wake = |(pend & ena);
endmodule // ptc_wake

//--- ptc_trap_ctrl.v
// Chosen here: the address map and register access over Wishbone.
`include "ptc_consts.vh"
// Functional notes
// - Env request traps per level, nothing else
// - Env causes 8, 9, 11 by level
// - Debug stop raises breakpoint only
// - Compressed debug stop behaves identically
// - Env/debug traps save own address
// - Decode under system opcode, trap_minor_op minor function
// - Machine return always; others configurable
// - Return allowed at same or higher level
// - Return loads pc from saved pc
// - Idle may stall or act as nop
// - Idle in S and M; U optional
// - Interrupt after idle saves idle+4
// - Idle with nonzero regs is illegal
// - Wake on enabled pending, ignore globals
// - Stay stalled if enable clear
// - Wake without interrupt resumes at +4
// - Idle may trap to higher level
// - Reset: machine level, enables clear, vector
// - Reset cause zero
// - Unmaskable error jumps to fixed vector
// - Unmaskable error saves next pc, cause
// - Unmaskable cause zero means unknown
// - Unmaskable error changes nothing else; here it also forces machine level and ends an idle stall
// - Interrupt flag is cause top bit
module ptc_trap_ctrl #(
    parameter NIRQ = 12,
    parameter HAS_S = 1,
    parameter HAS_U_TRAPS = 0
) (
    input wire REF_CLK,
    input wire RESET,
    input wire INSTR_VALID,
    input wire [31:0] INSTR,
    input wire [31:0] INSTR_PC,
    input wire [NIRQ-1:0] IRQ_PEND,
    input wire [NIRQ-1:0] IRQ_ENA,
    input wire IRQ_TAKE,
    input wire [4:0] IRQ_CODE,
    input wire NMI,
    input wire [31:0] WB_ADR_I,
    input wire [31:0] WB_DAT_I,
    input wire [3:0] WB_SEL_I,
    input wire WB_WE_I,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    output reg [31:0] WB_DAT_O,
    output reg WB_ACK_O,
    output reg PC_LOAD,
    output reg [31:0] PC_NEXT,
    output reg STALL,
    output reg [1:0] TRAP_MINOR_OP_LEVEL,
    output reg MACHINE_GLOBAL_IRQ_ENABLE,
    output reg MODIFY_PRIVILEGE_FLAG,
    output reg [31:0] TRAP_PC,
    output reg [31:0] TRAP_REASON
);
    // Idle controller states
    localparam ST_RUN = 1'b0;
    localparam ST_IDLE = 1'b1;
    // Decoder outputs, one strobe per recognised instruction
    // Environment request and full or compressed debug stop
    wire is_env;
    wire is_dbg;
    // Trap returns for each level
    wire is_user_return;
    wire is_supervisor_return;
    wire is_top_level_return;
    // Idle with clean register fields, and with dirty ones
    wire is_idle;
    wire idle_bad;
    // Some individually enabled interrupt is pending
    wire wake;
    // Saved pcs for lower levels
    // Only read by their own returns; software loads them elsewhere
    reg [31:0] sepc_q;
    reg [31:0] uepc_q;
    // Supervisor / user enable stacks (pushed outside this block)
    // Supervisor enable, prior enable and prior level
    reg sie_q;
    reg spie_q;
    reg spp_q;
    // User enable and prior enable
    reg uie_q;
    reg upie_q;
    // Machine prior enable and prior level
    reg mpie_q;
    reg [1:0] mpp_q;
    // Control register: idle as nop, idle timeout trap enable
    reg idle_nop_q;
    reg idle_trap_q;
    // Idle cycles allowed before the timeout trap
    reg [15:0] idle_limit_q;
    // Cycles spent stalled so far
    reg [15:0] idle_cnt_q;
    // Run or idle
    reg state_q;
    // Address of the idle instruction being waited on
    reg [31:0] idle_pc_q;
    // New bus request this cycle
    reg wb_hit;
    // Register selector; addresses outside the map select a hole
    wire [3:0] reg_sel;
    // Instruction accepted this cycle
    wire go;
    // Return legality
    // Each is high only for a return allowed at the current level
    wire top_level_return_ok;
    wire supervisor_return_ok;
    wire user_return_ok;
    // Idle allowed at the current level
    wire idle_ok;

    // Instruction classifier for the system opcode family
    // Purely combinational; valid qualifies its strobes here
    ptc_decode u_dec (
        .instr(INSTR),
        .is_env(is_env),
        .is_dbg(is_dbg),
        .is_user_return(is_user_return),
        .is_supervisor_return(is_supervisor_return),
        .is_top_level_return(is_top_level_return),
        .is_idle(is_idle),
        .idle_bad(idle_bad)
    );

    // Wake detector: pending and individually enabled, globals ignored
    // Also ends the stall when no interrupt is taken
    ptc_wake #(.NIRQ(NIRQ)) u_wake (
        .pend(IRQ_PEND),
        .ena(IRQ_ENA),
        .wake(wake)
    );

    // Instruction accepted only while running
    assign go = INSTR_VALID && (state_q == ST_RUN);
    // Machine return only at machine level, supervisor by configuration and level, user by configuration
    assign top_level_return_ok = is_top_level_return && TRAP_MINOR_OP_LEVEL == `PTC_LVL_M;
    assign supervisor_return_ok = is_supervisor_return && (HAS_S != 0) &&
        TRAP_MINOR_OP_LEVEL >= `PTC_LVL_S;
    assign user_return_ok = is_user_return && (HAS_U_TRAPS != 0);
    // Idle legal at S and M, at U only with user traps
    assign idle_ok = is_idle && (TRAP_MINOR_OP_LEVEL != `PTC_LVL_U ||
        HAS_U_TRAPS != 0);

    // Only the low nibble selects a register; anything above is a hole.
    // The hole code names no register, so it reaches the default branch.
    assign reg_sel = (WB_ADR_I[31:4] == 28'h0000000) ? WB_ADR_I[3:0] :
        `PTC_REG_HOLE;

    // New request: strobe up and not already answered
    always @* begin
        wb_hit = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    end

    // Wishbone slave: single-cycle ack, registers word wide
    // A request is taken once; ack then stands for one cycle and the
    // next edge drops it, so a held strobe is not taken again in the ack cycle.
    // Read data is registered with ack and stays until the next request, read or write.
    // Writes to read-only or unmapped words are dropped quietly.
    always @(posedge REF_CLK) begin
        if (RESET) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
            idle_nop_q <= 1'b0;
            idle_trap_q <= 1'b0;
            idle_limit_q <= 16'hffff;
        end else begin
            // Ack one cycle, dropped the cycle after
            WB_ACK_O <= wb_hit;
            if (wb_hit) begin
                WB_DAT_O <= 32'h0000_0000;
                case (reg_sel)
                    `PTC_REG_CTRL: begin
                        WB_DAT_O <= {idle_limit_q, 14'h0000,
                            idle_trap_q, idle_nop_q};
                        if (WB_WE_I && WB_SEL_I[0]) begin
                            idle_nop_q <= WB_DAT_I[0];
                            idle_trap_q <= WB_DAT_I[1];
                        end
                        if (WB_WE_I && WB_SEL_I[2]) begin
                            idle_limit_q[7:0] <= WB_DAT_I[23:16];
                        end
                        if (WB_WE_I && WB_SEL_I[3]) begin
                            idle_limit_q[15:8] <= WB_DAT_I[31:24];
                        end
                    end
                    `PTC_REG_STATUS: begin
                        WB_DAT_O <= {27'h0000000, state_q,
                            MODIFY_PRIVILEGE_FLAG,
                            MACHINE_GLOBAL_IRQ_ENABLE, TRAP_MINOR_OP_LEVEL};
                    end
                    `PTC_REG_EPC: begin
                        WB_DAT_O <= TRAP_PC;
                    end
                    `PTC_REG_CAUSE: begin
                        WB_DAT_O <= TRAP_REASON;
                    end
                    default: begin
                        WB_DAT_O <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    // Trap, return, idle and unmaskable-error sequencing
    // Priority: unmaskable error, then the idle wait, then a new
    // instruction. While stalled, offered instructions are ignored.
    // Every redirect after reset raises PC_LOAD for one cycle; reset holds it high while RESET is high.
    // Traps of this block always land in machine level.
    // Lower-level stacks are popped here but pushed elsewhere.
    always @(posedge REF_CLK) begin
        if (RESET) begin
            // Hart reset state
            TRAP_MINOR_OP_LEVEL <= `PTC_LVL_M;
            MACHINE_GLOBAL_IRQ_ENABLE <= 1'b0;
            MODIFY_PRIVILEGE_FLAG <= 1'b0;
            PC_LOAD <= 1'b1;
            PC_NEXT <= `PTC_RESET_VEC;
            TRAP_REASON <= {27'h0000000, `PTC_RESET_CAUSE};
            TRAP_PC <= 32'h0000_0000;
            STALL <= 1'b0;
            state_q <= ST_RUN;
            idle_pc_q <= 32'h0000_0000;
            idle_cnt_q <= 16'h0000;
            sepc_q <= 32'h0000_0000;
            uepc_q <= 32'h0000_0000;
            sie_q <= 1'b0;
            spie_q <= 1'b0;
            spp_q <= 1'b0;
            uie_q <= 1'b0;
            upie_q <= 1'b0;
            mpie_q <= 1'b0;
            mpp_q <= `PTC_LVL_M;
        end else begin
            PC_LOAD <= 1'b0;
            if (NMI) begin
                // Unmaskable: ignores enables, sets pc/epc/cause, forces machine level, ends any idle stall
                PC_LOAD <= 1'b1;
                PC_NEXT <= `PTC_NMI_VEC;
                TRAP_MINOR_OP_LEVEL <= `PTC_LVL_M;
                // Next instruction: idle resume point or current one
                TRAP_PC <= (state_q == ST_IDLE) ?
                    idle_pc_q + `PTC_PC_STEP : INSTR_PC;
                // Sources not told apart: the whole word is the unknown code
                TRAP_REASON <= {27'h0000000,
                    `PTC_NMI_CAUSE};
                state_q <= ST_RUN;
                STALL <= 1'b0;
            end else if (state_q == ST_IDLE) begin
                idle_cnt_q <= idle_cnt_q + 16'h0001;
                if (IRQ_TAKE) begin
                    // Interrupt taken on instruction after idle
                    TRAP_PC <= idle_pc_q + `PTC_PC_STEP;
                    TRAP_REASON <= {1'b1, 26'h0000000,
                        IRQ_CODE};
                    TRAP_MINOR_OP_LEVEL <= `PTC_LVL_M;
                    MACHINE_GLOBAL_IRQ_ENABLE <= 1'b0;
                    PC_LOAD <= 1'b1;
                    PC_NEXT <= `PTC_TRAP_VEC;
                    state_q <= ST_RUN;
                    STALL <= 1'b0;
                end else if (wake) begin
                    // Woken without trap: continue after idle
                    PC_LOAD <= 1'b1;
                    PC_NEXT <= idle_pc_q + `PTC_PC_STEP;
                    state_q <= ST_RUN;
                    STALL <= 1'b0;
                end else if (idle_trap_q && idle_cnt_q == idle_limit_q) begin
                    // Timed-out idle traps to machine as illegal
                    TRAP_PC <= idle_pc_q;
                    TRAP_REASON <= {27'h0000000,
                        `PTC_EXC_ILLEGAL};
                    TRAP_MINOR_OP_LEVEL <= `PTC_LVL_M;
                    PC_LOAD <= 1'b1;
                    PC_NEXT <= `PTC_TRAP_VEC;
                    state_q <= ST_RUN;
                    STALL <= 1'b0;
                end
            end else if (go) begin
                if (is_env || is_dbg || idle_bad ||
                    (is_idle && !idle_ok) ||
                    ((is_top_level_return || is_supervisor_return || is_user_return) &&
                    !(top_level_return_ok || supervisor_return_ok || user_return_ok))) begin
                    // Synchronous exception into machine level
                    TRAP_PC <= INSTR_PC;
                    TRAP_MINOR_OP_LEVEL <= `PTC_LVL_M;
                    PC_LOAD <= 1'b1;
                    PC_NEXT <= `PTC_TRAP_VEC;
                    // Cause code by originating level or kind
                    if (is_env) begin
                        case (TRAP_MINOR_OP_LEVEL)
                            `PTC_LVL_U: TRAP_REASON <=
                                {27'h0000000, `PTC_EXC_ENV_U};
                            `PTC_LVL_S: TRAP_REASON <=
                                {27'h0000000, `PTC_EXC_ENV_S};
                            default: TRAP_REASON <=
                                {27'h0000000, `PTC_EXC_ENV_M};
                        endcase
                    end else if (is_dbg) begin
                        TRAP_REASON <= {27'h0000000,
                            `PTC_EXC_BREAK};
                    end else begin
                        TRAP_REASON <= {27'h0000000,
                            `PTC_EXC_ILLEGAL};
                    end
                end else if (top_level_return_ok) begin
                    // Pop machine stack, return via saved pc
                    PC_LOAD <= 1'b1;
                    PC_NEXT <= TRAP_PC;
                    MACHINE_GLOBAL_IRQ_ENABLE <= mpie_q;
                    mpie_q <= 1'b1;
                    TRAP_MINOR_OP_LEVEL <= mpp_q;
                    mpp_q <= `PTC_LVL_U;
                end else if (supervisor_return_ok) begin
                    // Lower-level return pops supervisor stack
                    PC_LOAD <= 1'b1;
                    PC_NEXT <= sepc_q;
                    sie_q <= spie_q;
                    spie_q <= 1'b1;
                    TRAP_MINOR_OP_LEVEL <= spp_q ? `PTC_LVL_S : `PTC_LVL_U;
                    spp_q <= 1'b0;
                end else if (user_return_ok) begin
                    // User return pops user stack
                    PC_LOAD <= 1'b1;
                    PC_NEXT <= uepc_q;
                    uie_q <= upie_q;
                    upie_q <= 1'b1;
                end else if (idle_ok) begin
                    if (idle_nop_q) begin
                        // Nop mode: just step past
                        PC_LOAD <= 1'b1;
                        PC_NEXT <= INSTR_PC + `PTC_PC_STEP;
                    end else begin
                        // Stall until woken
                        state_q <= ST_IDLE;
                        STALL <= 1'b1;
                        idle_pc_q <= INSTR_PC;
                        idle_cnt_q <= 16'h0000;
                    end
                end
            end
        end
    end
endmodule // ptc_trap_ctrl

//--- ptc_trap_ctrl_sva.sv
module ptc_trap_ctrl_chk #(
    parameter NIRQ = 12
) (
    input wire REF_CLK,
    input wire RESET,
    input wire INSTR_VALID,
    input wire [31:0] INSTR,
    input wire [31:0] INSTR_PC,
    input wire [NIRQ-1:0] IRQ_PEND,
    input wire [NIRQ-1:0] IRQ_ENA,
    input wire IRQ_TAKE,
    input wire NMI,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_ACK_O,
    input wire PC_LOAD,
    input wire [31:0] PC_NEXT,
    input wire STALL,
    input wire [1:0] TRAP_MINOR_OP_LEVEL,
    input wire MACHINE_GLOBAL_IRQ_ENABLE,
    input wire MODIFY_PRIVILEGE_FLAG,
    input wire [31:0] TRAP_PC,
    input wire [31:0] TRAP_REASON
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RESET);
    // Instruction accepted, no unmaskable error beside it
    wire go = INSTR_VALID && !STALL && !NMI;
    // Some interrupt both pending and individually enabled
    wire wake = |(IRQ_PEND & IRQ_ENA);
    // Address of the last accepted idle instruction
    reg [31:0] idle_pc_q;
    // Latch the idle address so wake targets can be checked
    always @(posedge REF_CLK) begin
        if (go && INSTR == 32'h1050_0073) begin
            idle_pc_q <= INSTR_PC;
        end
    end
    rst_state_a: assert property ($fell(RESET) |-> TRAP_MINOR_OP_LEVEL == 2'h3
        && !MACHINE_GLOBAL_IRQ_ENABLE && !MODIFY_PRIVILEGE_FLAG && PC_LOAD
        && PC_NEXT == 32'h0 && TRAP_REASON == 32'h0) else $error("bad reset");
    env_cause_a: assert property (go && INSTR == 32'h73 |=> PC_LOAD
        && TRAP_PC == $past(INSTR_PC) && TRAP_REASON == ($past(TRAP_MINOR_OP_LEVEL) == 2'h0
        ? 32'h8 : $past(TRAP_MINOR_OP_LEVEL) == 2'h1 ? 32'h9 : 32'hb)) else $error("env");
    dbg_stop_a: assert property (go && (INSTR == 32'h0010_0073
        || INSTR == 32'h9002) |=> PC_LOAD && TRAP_REASON == 32'h3
        && TRAP_PC == $past(INSTR_PC)) else $error("debug stop");
    ret_pc_a: assert property (go && INSTR == 32'h3020_0073
        && TRAP_MINOR_OP_LEVEL == 2'h3 |=> PC_LOAD && PC_NEXT == $past(TRAP_PC))
        else $error("return pc");
    idle_bad_a: assert property (go && INSTR[31:20] == 12'h105
        && INSTR[14:12] == 3'h0 && INSTR[6:0] == 7'h73 && INSTR[19:7] != 13'h0
        |=> TRAP_REASON == 32'h2 && !STALL) else $error("idle fields");
    idle_hold_a: assert property (STALL && !wake && !IRQ_TAKE && !NMI
        |=> STALL || (PC_LOAD && PC_NEXT == 32'h100 && TRAP_REASON == 32'h2))
        else $error("left stall");
    wake_up_a: assert property (STALL && wake && !IRQ_TAKE && !NMI
        |=> PC_LOAD && !STALL && PC_NEXT == idle_pc_q + 32'h4) else $error("wake");
    idle_take_a: assert property (STALL && IRQ_TAKE && !NMI
        |=> TRAP_PC == idle_pc_q + 32'h4 && TRAP_REASON[31]) else $error("take");
    err_entry_a: assert property (NMI |=> PC_LOAD && PC_NEXT == 32'h4
        && TRAP_MINOR_OP_LEVEL == 2'h3 && TRAP_REASON == 32'h0
        && MODIFY_PRIVILEGE_FLAG == $past(MODIFY_PRIVILEGE_FLAG)) else $error("nmi");
    wb_ack_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O
        |=> WB_ACK_O ##1 !WB_ACK_O) else $error("bus ack");
    cover property (STALL && wake);
    cover property (NMI);
    cover property (go && INSTR == 32'h9002);
endmodule // ptc_trap_ctrl_chk

bind ptc_trap_ctrl ptc_trap_ctrl_chk #(.NIRQ(NIRQ)) u_chk (.*);

//--- ptc_pipe_model.sv
// Pipeline and interrupt sources facing the trap block
module ptc_pipe_model (
    input wire clk,
    input wire stall,
    output logic instr_valid,
    output logic [31:0] instr,
    output logic [31:0] instr_pc,
    output logic [11:0] irq_pend,
    output logic [11:0] irq_ena,
    output logic irq_take,
    output logic [4:0] irq_code,
    output logic nmi
);
    timeunit 1ns;
    timeprecision 1ns;
    // Quiet sources at time zero
    initial begin
        {instr_valid, irq_take, nmi, irq_code} = 8'h0;
        {instr, instr_pc, irq_pend, irq_ena} = 88'h0;
    end
    // Offer one instruction, held while stalled, then wait for its effect
    task automatic issue(input logic [31:0] w, input logic [31:0] pc);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr <= w;
        instr_pc <= pc;
        @(posedge clk);
        while (stall) @(posedge clk);
        instr_valid <= 1'b0;
        instr <= ~w;
        #1;
    endtask
    // Level pending and enable bits
    task automatic set_irq(input logic [11:0] p, input logic [11:0] e);
        @(posedge clk);
        irq_pend <= p;
        irq_ena <= e;
    endtask
    // One-cycle unmaskable error or interrupt take
    task automatic pulse(input logic err, input logic [4:0] c);
        @(posedge clk);
        nmi <= err;
        irq_take <= !err;
        irq_code <= c;
        @(posedge clk);
        nmi <= 1'b0;
        irq_take <= 1'b0;
        #1;
    endtask
endmodule // ptc_pipe_model

//--- privileged_trap_control_tb.sv
module privileged_trap_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [31:0] adr = 32'h0;
    logic [31:0] wdat = 32'h0;
    logic [3:0] sel = 4'hf;
    logic [31:0] r;
    wire ack, ivalid, take, nmi, pc_load, stall, machine_global_irq_enable, modify_privilege_flag;
    wire [31:0] rdat, instr, ipc, pc_next, trap_pc, reason;
    wire [11:0] pend, ena;
    wire [4:0] code;
    wire [1:0] trap_minor_op;
    int err_total = 0;
    int tests_run = 0;
    int cycles = 0;
    // Trap instructions and their expected causes
    logic [31:0] ops [6] = '{32'h73, 32'h0010_0073, 32'h9002,
        32'h0020_0073, 32'h1050_8073, 32'h1050_00f3};
    logic [31:0] why [6] = '{32'hb, 32'h3, 32'h3, 32'h2, 32'h2, 32'h2};
    always #50 clk = ~clk;
    ptc_trap_ctrl u_dut (
        .REF_CLK(clk), .RESET(rst), .INSTR_VALID(ivalid), .INSTR(instr),
        .INSTR_PC(ipc), .IRQ_PEND(pend), .IRQ_ENA(ena), .IRQ_TAKE(take),
        .IRQ_CODE(code), .NMI(nmi), .WB_ADR_I(adr), .WB_DAT_I(wdat),
        .WB_SEL_I(sel), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_DAT_O(rdat), .WB_ACK_O(ack), .PC_LOAD(pc_load),
        .PC_NEXT(pc_next), .STALL(stall), .TRAP_MINOR_OP_LEVEL(trap_minor_op),
        .MACHINE_GLOBAL_IRQ_ENABLE(machine_global_irq_enable), .MODIFY_PRIVILEGE_FLAG(modify_privilege_flag),
        .TRAP_PC(trap_pc), .TRAP_REASON(reason)
    );
    ptc_pipe_model u_pipe (
        .clk(clk), .stall(stall), .instr_valid(ivalid), .instr(instr),
        .instr_pc(ipc), .irq_pend(pend), .irq_ena(ena), .irq_take(take),
        .irq_code(code), .nmi(nmi)
    );
    // Classic single bus cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [31:0] a,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    // Compare and count
    task automatic ck(input logic [31:0] got, input logic [31:0] exp,
        input string m);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // Verdict and end of run
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            summarize();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        #1;
        ck({trap_minor_op, machine_global_irq_enable, modify_privilege_flag}, 32'hc, "reset level");
        ck(pc_load, 32'h1, "reset redirect");
        ck(pc_next, 32'h0, "reset vector");
        ck(reason, 32'h0, "reset cause");
        wb(1'b0, 32'h0, 32'h0, r);
        ck(r, 32'hffff_0000, "ctrl reset");
        wb(1'b1, 32'h10, 32'hffff_ffff, r);
        wb(1'b0, 32'h10, 32'h0, r);
        ck(r, 32'h0, "unmapped read");
        wb(1'b1, 32'hc, 32'hffff_ffff, r);
        wb(1'b0, 32'hc, 32'h0, r);
        ck(r, 32'h0, "cause read only");
        wb(1'b0, 32'h4, 32'h0, r);
        ck(r, 32'h3, "status after reset");
        for (int i = 0; i < 6; i++) begin
            u_pipe.issue(ops[i], 32'h200 + 32'(i * 4));
            ck(reason, why[i], "trap cause");
            ck(pc_next, 32'h100, "trap vector");
            if (i < 3) ck(trap_pc, 32'h200 + 32'(i * 4), "trap pc");
        end
        u_pipe.issue(32'h3020_0073, 32'h300);
        ck(pc_load, 32'h1, "return redirect");
        ck(pc_next, 32'h214, "return target");
        ck(trap_minor_op, 32'h3, "return level");
        u_pipe.set_irq(12'h080, 12'h000);
        u_pipe.issue(32'h1050_0073, 32'h700);
        repeat (5) @(posedge clk);
        #1;
        ck(stall, 32'h1, "stall with enable clear");
        u_pipe.set_irq(12'h080, 12'h080);
        @(posedge clk);
        #1;
        ck(stall, 32'h0, "wake");
        ck(pc_next, 32'h704, "resume address");
        u_pipe.set_irq(12'h000, 12'h000);
        u_pipe.issue(32'h1050_0073, 32'h800);
        u_pipe.pulse(1'b0, 5'h07);
        ck(trap_pc, 32'h804, "idle irq pc");
        ck(reason, 32'h8000_0007, "irq cause");
        u_pipe.issue(32'h1050_0073, 32'h900);
        u_pipe.pulse(1'b1, 5'h00);
        ck(pc_next, 32'h4, "error vector");
        ck(trap_pc, 32'h904, "error pc");
        ck(reason, 32'h0, "error cause");
        ck({trap_minor_op, machine_global_irq_enable, modify_privilege_flag}, 32'hc, "error keeps state");
        wb(1'b1, 32'h0, 32'h0003_0002, r);
        wb(1'b0, 32'h0, 32'h0, r);
        ck(r, 32'h0003_0002, "ctrl write");
        u_pipe.issue(32'h1050_0073, 32'ha00);
        repeat (3) @(posedge clk);
        #1;
        ck(stall, 32'h1, "idle before limit");
        @(posedge clk);
        #1;
        ck(stall, 32'h0, "idle timeout");
        ck(reason, 32'h2, "timeout cause");
        ck(trap_pc, 32'ha00, "timeout pc");
        wb(1'b1, 32'h0, 32'h0000_0001, r);
        u_pipe.issue(32'h1050_0073, 32'hb00);
        ck({stall, pc_load}, 32'h1, "idle as nop");
        ck(pc_next, 32'hb04, "nop step");
        u_pipe.issue(32'h1020_0073, 32'hc00);
        ck({pc_load, trap_minor_op}, 32'h4, "supervisor return");
        u_pipe.issue(32'h73, 32'hc04);
        ck(reason, 32'h8, "env from user");
        summarize();
    end
endmodule // privileged_trap_control_tb
